// [rtl/cti_terminal.sv]
// Configurable bidirectional terminal: input filter, events, pulse in/out, driver
//Operation
//- Inversion setting 1 inverts terminal signal
//- Fast debounce 0 to 63.5 us
//- Standard debounce 0 to 127 ms, default 5
//- Reaction setting picks 1 ms or 0.5 us tick
//- Fast reaction routes events as fast events
//- Trigger selects none, rising, falling, both edges
//- Pulse input min/max frequency map 0-100%
//- Pulse input frequency is an analog value
//- Pulse output frequency between min and max; a pout_pct above 10000 is not clamped, so the frequency leaves the range
//- Output type: tristate, sink, source, push-pull
//- Mode: off, dout, pout, din, pin
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module cti_terminal #(
  parameter int STD_TICK_CYC = cti_pkg::TICK_STD_CYC,
  parameter int GATE_LEN = cti_pkg::GATE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [cti_pkg::AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [31:0] rdata,
  // Terminal pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  // Events
  output logic event_out,
  output logic fast_event_out
);
  import cti_pkg::*;

  cti_cfg_s cfg_r;
  logic raw_r, filt_r, filt_d_r;
  logic [TW-1:0] cnt_r, cur_t;
  logic std_tick_r, fast_tick_r, tick;
  logic [17:0] std_cnt_r;
  logic [9:0] fast_acc_r;
  logic in_mode, out_mode;
  logic [31:0] gate_r;
  logic [CW-1:0] edge_cnt_r, meas_r, cnt_tot;
  logic [PW-1:0] pct_r, q_r;
  logic [30:0] rem_r;
  logic [FW-1:0] den_r;
  logic [3:0] bit_r;
  cti_div_e dv_r;
  logic [FW-1:0] pout_f_r;
  logic [27:0] nco_r;
  logic sq_r, drv_lvl, rise_now;
  logic [30:0] trial;

  assign in_mode = (cfg_r.mode == MD_DIN) || (cfg_r.mode == MD_PIN);
  assign out_mode = (cfg_r.mode == MD_DOUT) || (cfg_r.mode == MD_POUT);

  // Register writes; fields are kept at their documented widths
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_r <= '0;
      cfg_r.mode <= MODE_RST;
      cfg_r.std_t <= STD_T_RST;
      cfg_r.pin_max <= PIN_MAX_RST;
      cfg_r.pout_max <= POUT_MAX_RST;
    end else if (we) begin
      case (addr)
        IX_MODE: cfg_r.mode <= wdata[2:0];
        IX_INV: cfg_r.inv <= wdata[0];
        IX_FAST_T: cfg_r.fast_t <= wdata[TW-1:0];
        IX_STD_T: cfg_r.std_t <= wdata[TW-1:0];
        IX_REACT: cfg_r.react <= wdata[0];
        IX_TRIG: cfg_r.trig <= wdata[1:0];
        IX_PIN_MIN: cfg_r.pin_min <= wdata[FW-1:0];
        IX_PIN_MAX: cfg_r.pin_max <= wdata[FW-1:0];
        IX_OTYPE: cfg_r.otype <= wdata[1:0];
        IX_POUT_MIN: cfg_r.pout_min <= wdata[FW-1:0];
        IX_POUT_MAX: cfg_r.pout_max <= wdata[FW-1:0];
        IX_OUT_LVL: cfg_r.out_lvl <= wdata[0];
        IX_POUT_PCT: cfg_r.pout_pct <= wdata[PW-1:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped words read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= '0;
    end else if (re) begin
      case (addr)
        IX_MODE: rdata <= {29'h0, cfg_r.mode};
        IX_INV: rdata <= {31'h0, cfg_r.inv};
        IX_FAST_T: rdata <= {25'h0, cfg_r.fast_t};
        IX_STD_T: rdata <= {25'h0, cfg_r.std_t};
        IX_REACT: rdata <= {31'h0, cfg_r.react};
        IX_TRIG: rdata <= {30'h0, cfg_r.trig};
        IX_PIN_MIN: rdata <= {15'h0, cfg_r.pin_min};
        IX_PIN_MAX: rdata <= {15'h0, cfg_r.pin_max};
        IX_OTYPE: rdata <= {30'h0, cfg_r.otype};
        IX_POUT_MIN: rdata <= {15'h0, cfg_r.pout_min};
        IX_POUT_MAX: rdata <= {15'h0, cfg_r.pout_max};
        IX_OUT_LVL: rdata <= {31'h0, cfg_r.out_lvl};
        IX_POUT_PCT: rdata <= {18'h0, cfg_r.pout_pct};
        IX_STATUS: rdata <= {30'h0, pin_in, filt_r};
        IX_MEAS_HZ: rdata <= {12'h0, meas_r};
        IX_MEAS_PCT: rdata <= {18'h0, pct_r};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // Tick dividers; 0.5 us is not a whole cycle count, so a ns accumulator
  // alternates 62 and 63 cycles to hold the mean exactly
  always_ff @(posedge clk) begin
    if (srst) begin
      std_cnt_r <= '0;
      std_tick_r <= 1'b0;
      fast_acc_r <= '0;
      fast_tick_r <= 1'b0;
    end else begin
      std_tick_r <= (std_cnt_r == 18'(STD_TICK_CYC - 1));
      std_cnt_r <= (std_cnt_r == 18'(STD_TICK_CYC - 1)) ? '0 : std_cnt_r + 18'h0_0001;
      if (fast_acc_r + 10'(CLK_NS) >= 10'(TICK_FAST_NS)) begin
        fast_acc_r <= fast_acc_r + 10'(CLK_NS) - 10'(TICK_FAST_NS);
        fast_tick_r <= 1'b1;
      end else begin
        fast_acc_r <= fast_acc_r + 10'(CLK_NS);
        fast_tick_r <= 1'b0;
      end
    end
  end

  assign tick = cfg_r.react ? fast_tick_r : std_tick_r;
  assign cur_t = cfg_r.react ? cfg_r.fast_t : cfg_r.std_t;

  // Inversion ahead of the filter, so edges refer to the inverted level
  always_ff @(posedge clk) begin
    if (srst) begin
      raw_r <= 1'b0;
      filt_r <= 1'b0;
      filt_d_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      raw_r <= pin_in ^ cfg_r.inv;
      filt_d_r <= filt_r;
      if (!in_mode || raw_r == filt_r) begin
        cnt_r <= '0;
      end else if (cnt_r >= cur_t) begin
        filt_r <= raw_r;
        cnt_r <= '0;
      end else if (tick) begin
        cnt_r <= cnt_r + 7'h01;
      end
    end
  end

  // Edge events on the filtered level; fast reaction has its own strobe
  always_ff @(posedge clk) begin
    logic hit;
    hit = 1'b0;
    if (srst) begin
      event_out <= 1'b0;
      fast_event_out <= 1'b0;
    end else begin
      case (cfg_r.trig)
        TRG_RISE: hit = filt_r & ~filt_d_r;
        TRG_FALL: hit = ~filt_r & filt_d_r;
        TRG_BOTH: hit = filt_r ^ filt_d_r;
        default: hit = 1'b0;
      endcase
      hit = hit && (cfg_r.mode == MD_DIN);
      event_out <= hit && !cfg_r.react;
      fast_event_out <= hit && cfg_r.react;
    end
  end

  // Edge in the gate's last cycle is counted too, so no edge falls between two gates
  assign rise_now = filt_r && !filt_d_r;
  assign cnt_tot = (rise_now && edge_cnt_r != '1) ? edge_cnt_r + 20'h0_0001 : edge_cnt_r;

  // Frequency gate: rising edges counted over a one second window
  always_ff @(posedge clk) begin
    if (srst || cfg_r.mode != MD_PIN) begin
      gate_r <= '0;
      edge_cnt_r <= '0;
      meas_r <= '0;
    end else if (gate_r == 32'(GATE_LEN - 1)) begin
      gate_r <= '0;
      meas_r <= cnt_tot;
      edge_cnt_r <= '0;
    end else begin
      gate_r <= gate_r + 32'h0000_0001;
      edge_cnt_r <= cnt_tot;
    end
  end

  // Percent mapping: clamp first, then a 14 step restoring divide
  assign trial = 31'({den_r, 14'h0} >> (4'd14 - bit_r));
  always_ff @(posedge clk) begin
    if (srst) begin
      dv_r <= DV_IDLE;
      pct_r <= '0;
      q_r <= '0;
      rem_r <= '0;
      den_r <= '0;
      bit_r <= '0;
    end else begin
      case (dv_r)
        DV_IDLE: begin
          if (cfg_r.mode == MD_PIN && gate_r == 32'(GATE_LEN - 1)) begin
            if (cnt_tot >= CW'(cfg_r.pin_max)) begin
              pct_r <= PCT_FULL;
            end else if (cnt_tot <= CW'(cfg_r.pin_min)) begin
              pct_r <= '0;
            end else begin
              rem_r <= 31'(cnt_tot - CW'(cfg_r.pin_min)) * 31'(PCT_FULL);
              den_r <= cfg_r.pin_max - cfg_r.pin_min;
              q_r <= '0;
              bit_r <= 4'hD;
              dv_r <= DV_BUSY;
            end
          end
        end
        DV_BUSY: begin
          if (rem_r >= trial) begin
            rem_r <= rem_r - trial;
            q_r[bit_r] <= 1'b1;
          end
          if (bit_r == 4'h0) begin
            dv_r <= DV_IDLE;
            pct_r <= (rem_r >= trial) ? (q_r | 14'h0001) : q_r;
          end else begin
            bit_r <= bit_r - 4'h1;
          end
        end
        default: dv_r <= DV_IDLE;
      endcase
    end
  end

  // Output frequency; a reversed range runs downward from the minimum
  always_ff @(posedge clk) begin
    if (srst) begin
      pout_f_r <= '0;
    end else if (cfg_r.pout_max >= cfg_r.pout_min) begin
      pout_f_r <= cfg_r.pout_min + FW'((31'(cfg_r.pout_max - cfg_r.pout_min)
        * 31'(cfg_r.pout_pct)) / 31'(PCT_FULL));
    end else begin
      pout_f_r <= cfg_r.pout_min - FW'((31'(cfg_r.pout_min - cfg_r.pout_max)
        * 31'(cfg_r.pout_pct)) / 31'(PCT_FULL));
    end
  end

  // Square wave oscillator: two toggles per period at the chosen frequency
  always_ff @(posedge clk) begin
    if (srst || cfg_r.mode != MD_POUT) begin
      nco_r <= '0;
      sq_r <= 1'b0;
    end else if (nco_r + {pout_f_r, 1'b0} >= 28'(CLK_HZ)) begin
      nco_r <= nco_r + {pout_f_r, 1'b0} - 28'(CLK_HZ);
      sq_r <= ~sq_r;
    end else begin
      nco_r <= nco_r + {10'h000, pout_f_r, 1'b0};
    end
  end

  assign drv_lvl = ((cfg_r.mode == MD_POUT) ? sq_r : cfg_r.out_lvl) ^ cfg_r.inv;

  // Pin driver; enable low while driving, idle types release the pin
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end else if (!out_mode) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      case (cfg_r.otype)
        OT_SINK: begin
          pin_out <= 1'b0;
          pin_oe_n <= ~drv_lvl;
        end
        OT_SRC: begin
          pin_out <= 1'b1;
          pin_oe_n <= ~drv_lvl;
        end
        OT_PP: begin
          pin_out <= drv_lvl;
          pin_oe_n <= 1'b0;
        end
        default: begin
          pin_out <= 1'b0;
          pin_oe_n <= 1'b1;
        end
      endcase
    end
  end

  a_inv_pass: assert property (@(posedge clk) disable iff (srst)
    (in_mode && cur_t == '0) |=> filt_r == $past(pin_in ^ cfg_r.inv, 2))
    else $error("filtered level does not follow inverted pin");
  a_filter_hold: assert property (@(posedge clk) disable iff (srst)
    (filt_r != $past(filt_r)) |-> $past(cnt_r >= cur_t && in_mode))
    else $error("filter changed before its time");
  a_fast_tick_gap: assert property (@(posedge clk) disable iff (srst)
    fast_tick_r |=> !fast_tick_r [*8])
    else $error("fast tick spacing too short");
  a_evt_rise: assert property (@(posedge clk) disable iff (srst)
    ($rose(filt_r) && cfg_r.trig == TRG_RISE && cfg_r.mode == MD_DIN)
    |=> (event_out || fast_event_out))
    else $error("rising edge event missing");
  a_evt_none: assert property (@(posedge clk) disable iff (srst)
    (cfg_r.trig == TRG_NONE || cfg_r.mode == MD_PIN) |=> !event_out && !fast_event_out)
    else $error("event raised with trigger off");
  a_fast_route: assert property (@(posedge clk) disable iff (srst)
    fast_event_out |-> $past(cfg_r.react) && !event_out)
    else $error("fast event without fast reaction");
  a_pct_clamp: assert property (@(posedge clk) disable iff (srst)
    pct_r <= PCT_FULL)
    else $error("percent above full scale");
  a_pout_range: assert property (@(posedge clk) disable iff (srst)
    $stable(cfg_r) && cfg_r.pout_min <= cfg_r.pout_max
    |-> pout_f_r >= cfg_r.pout_min && pout_f_r <= cfg_r.pout_max)
    else $error("output frequency outside range");
  a_oe_release: assert property (@(posedge clk) disable iff (srst)
    (!out_mode || cfg_r.otype == OT_TRI) |=> pin_oe_n)
    else $error("pin driven while released");
  a_push_pull: assert property (@(posedge clk) disable iff (srst)
    (out_mode && cfg_r.otype == OT_PP) |=> !pin_oe_n && pin_out == $past(drv_lvl))
    else $error("push pull not driving level");
endmodule : cti_terminal

// [rtl/cti_pkg.sv]
// Shared constants, codes and carrier types for the configurable terminal block
package cti_pkg;
  // Clock and tick timing
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_NS = 8;
  localparam int NS_PER_MS = 1_000_000;
  localparam int TICK_STD_MS = 1;
  localparam int TICK_FAST_NS = 500;
  localparam int TICK_STD_CYC = TICK_STD_MS * NS_PER_MS / CLK_NS;
  localparam int GATE_S = 1;
  localparam int GATE_CYC = GATE_S * CLK_HZ;
  // Widths
  localparam int FW = 17;
  localparam int TW = 7;
  localparam int PW = 14;
  localparam int AW = 5;
  localparam int CW = 20;
  localparam logic [PW-1:0] PCT_FULL = 14'h2710;
  // Register indexes (word addresses)
  localparam logic [AW-1:0] IX_MODE = 5'h00;
  localparam logic [AW-1:0] IX_INV = 5'h01;
  localparam logic [AW-1:0] IX_FAST_T = 5'h02;
  localparam logic [AW-1:0] IX_STD_T = 5'h03;
  localparam logic [AW-1:0] IX_REACT = 5'h04;
  localparam logic [AW-1:0] IX_TRIG = 5'h05;
  localparam logic [AW-1:0] IX_PIN_MIN = 5'h06;
  localparam logic [AW-1:0] IX_PIN_MAX = 5'h07;
  localparam logic [AW-1:0] IX_OTYPE = 5'h08;
  localparam logic [AW-1:0] IX_POUT_MIN = 5'h09;
  localparam logic [AW-1:0] IX_POUT_MAX = 5'h0A;
  localparam logic [AW-1:0] IX_OUT_LVL = 5'h0B;
  localparam logic [AW-1:0] IX_POUT_PCT = 5'h0C;
  localparam logic [AW-1:0] IX_STATUS = 5'h0D;
  localparam logic [AW-1:0] IX_MEAS_HZ = 5'h0E;
  localparam logic [AW-1:0] IX_MEAS_PCT = 5'h0F;
  // Terminal modes
  localparam logic [2:0] MD_OFF = 3'h0;
  localparam logic [2:0] MD_DOUT = 3'h1;
  localparam logic [2:0] MD_POUT = 3'h2;
  localparam logic [2:0] MD_DIN = 3'h3;
  localparam logic [2:0] MD_PIN = 3'h4;
  // Trigger and output type codes
  localparam logic [1:0] TRG_NONE = 2'h0;
  localparam logic [1:0] TRG_RISE = 2'h1;
  localparam logic [1:0] TRG_FALL = 2'h2;
  localparam logic [1:0] TRG_BOTH = 2'h3;
  localparam logic [1:0] OT_TRI = 2'h0;
  localparam logic [1:0] OT_SINK = 2'h1;
  localparam logic [1:0] OT_SRC = 2'h2;
  localparam logic [1:0] OT_PP = 2'h3;
  // Reset values
  localparam logic [2:0] MODE_RST = MD_DIN;
  localparam logic [TW-1:0] STD_T_RST = 7'h05;
  localparam logic [FW-1:0] PIN_MAX_RST = 17'h1_ADB0;
  localparam logic [FW-1:0] POUT_MAX_RST = 17'h1_86A0;
  // Configuration carrier
  typedef struct packed {
    logic [2:0] mode;
    logic inv;
    logic [TW-1:0] fast_t;
    logic [TW-1:0] std_t;
    logic react;
    logic [1:0] trig;
    logic [FW-1:0] pin_min;
    logic [FW-1:0] pin_max;
    logic [1:0] otype;
    logic [FW-1:0] pout_min;
    logic [FW-1:0] pout_max;
    logic out_lvl;
    logic [PW-1:0] pout_pct;
  } cti_cfg_s;
  typedef enum logic {DV_IDLE, DV_BUSY} cti_div_e;
endpackage : cti_pkg

// [verif/cti_field_model.sv]
// Field-side model: a switch or pulse source on the terminal, beside the module driver
`timescale 1ns/1ps
module cti_field_model (
  // Clock
  input wire logic clk,
  // Field control from the bench
  input wire logic lvl,
  input wire logic [15:0] half,
  // Module driver side
  input wire logic pin_out,
  input wire logic pin_oe_n,
  // Wire level seen by the module
  output logic pin_in
);
  logic gen;
  logic [15:0] cnt;
  // Square wave of 2*half cycles; stands still at 0 while half is zero
  always_ff @(posedge clk) begin
    if (half == 16'h0000) begin
      cnt <= 16'h0000;
      gen <= 1'b0;
    end else if (cnt == half - 16'h0001) begin
      cnt <= 16'h0000;
      gen <= ~gen;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
  // The module's drive wins while enabled, so the wire never shows a stale field level
  assign pin_in = !pin_oe_n ? pin_out : ((half != 16'h0000) ? gen : lvl);
endmodule : cti_field_model

// [verif/tb_configurable_terminal_io.sv]
// Self-checking bench for the configurable terminal block
`timescale 1ns/1ps
module tb_configurable_terminal_io;
  import cti_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [AW-1:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [31:0] rdata;
  logic pin_in, pin_out, pin_oe_n, event_out, fast_event_out;
  logic lvl = 1'b0;
  logic [15:0] half = 16'h0000;
  logic [31:0] rv;
  int error_cnt = 0;
  int checks = 0;
  int ev_n, fev_n, edg_n;
  // Short tick and gate keep the run small; expectations use these values
  cti_terminal #(.STD_TICK_CYC(20), .GATE_LEN(1000)) cti_terminal_inst (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .event_out(event_out), .fast_event_out(fast_event_out));
  cti_field_model cti_field_model_inst (
    .clk(clk), .lvl(lvl), .half(half), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in));
  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  // One-cycle write; the idle cycle after it keeps strobes from being set twice in a step
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 rv = rdata;
  endtask : rd
  // Counts event pulses and driven rising pin edges over n cycles
  task automatic watch(input int n);
    logic prev;
    ev_n = 0;
    fev_n = 0;
    edg_n = 0;
    prev = pin_out;
    repeat (n) begin
      @(posedge clk);
      #1;
      ev_n += (event_out === 1'b1);
      fev_n += (fast_event_out === 1'b1);
      if (pin_oe_n === 1'b0 && pin_out === 1'b1 && prev === 1'b0) edg_n++;
      prev = pin_out;
    end
  endtask : watch
  task automatic t_defaults();
    logic [31:0] exp [13];
    exp = '{32'h3, 32'h0, 32'h0, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0001_ADB0,
            32'h0, 32'h0, 32'h0001_86A0, 32'h0, 32'h0};
    chk("oe_n after reset", 32'h1, {31'h0, pin_oe_n});
    for (int i = 0; i < 13; i++) begin
      rd(i[AW-1:0]);
      chk("reset value", exp[i], rv);
    end
    wr(5'h1F, 32'hFFFF_FFFF);
    rd(5'h1F);
    chk("unmapped read", 32'h0, rv);
    wr(IX_FAST_T, 32'h7F);
    rd(IX_FAST_T);
    chk("fast time max", 32'h7F, rv);
    wr(IX_STD_T, 32'h7F);
    rd(IX_STD_T);
    chk("std time max", 32'h7F, rv);
    $display("test defaults done");
  endtask : t_defaults
  // Every trigger code on fast reaction, then inversion ahead of edge detect
  task automatic t_events();
    wr(IX_REACT, 32'h1);
    wr(IX_FAST_T, 32'h0);
    for (int t = 0; t < 4; t++) begin
      wr(IX_TRIG, 32'(t));
      lvl <= 1'b1;
      watch(8);
      chk("rise events", {31'h0, t[0]}, 32'(fev_n));
      chk("std path quiet", 32'h0, 32'(ev_n));
      lvl <= 1'b0;
      watch(8);
      chk("fall events", {31'h0, t[1]}, 32'(fev_n));
    end
    wr(IX_TRIG, 32'h1);
    wr(IX_INV, 32'h1);
    watch(8);
    chk("inverted rise", 32'h1, 32'(fev_n));
    rd(IX_STATUS);
    chk("inverted level", 32'h1, {31'h0, rv[0]});
    lvl <= 1'b1;
    watch(8);
    chk("inverted fall", 32'h0, 32'(fev_n));
    wr(IX_INV, 32'h0);
    wr(IX_REACT, 32'h0);
    wr(IX_STD_T, 32'h0);
    lvl <= 1'b0;
    watch(8);
    lvl <= 1'b1;
    watch(8);
    chk("std event", 32'h1, 32'(ev_n));
    chk("fast path quiet", 32'h0, 32'(fev_n));
    $display("test events done");
  endtask : t_events
  // Glitches shorter than the filter are dropped; a long change passes in time
  task automatic t_filters();
    wr(IX_TRIG, 32'h3);
    wr(IX_STD_T, 32'h2);
    lvl <= 1'b0;
    watch(10);
    lvl <= 1'b1;
    watch(60);
    chk("std glitch", 32'h0, 32'(ev_n));
    lvl <= 1'b0;
    watch(15);
    chk("std early", 32'h0, 32'(ev_n));
    watch(60);
    chk("std accepted", 32'h1, 32'(ev_n));
    wr(IX_REACT, 32'h1);
    wr(IX_FAST_T, 32'h4);
    lvl <= 1'b1;
    watch(150);
    chk("fast early", 32'h0, 32'(fev_n));
    watch(150);
    chk("fast accepted", 32'h1, 32'(fev_n));
    $display("test filters done");
  endtask : t_filters
  // 20-cycle period gives 50 edges per 1000-cycle gate
  task automatic t_pulse_in();
    wr(IX_FAST_T, 32'h0);
    wr(IX_MODE, 32'h4);
    wr(IX_PIN_MAX, 32'h64);
    half <= 16'h000A;
    watch(2200);
    chk("pulse mode events", 32'h0, 32'(ev_n + fev_n));
    rd(IX_MEAS_HZ);
    chk("measured count", 32'h32, rv);
    rd(IX_MEAS_PCT);
    chk("mid percent", 32'h1388, rv);
    wr(IX_PIN_MAX, 32'h28);
    watch(1200);
    rd(IX_MEAS_PCT);
    chk("above max", 32'h2710, rv);
    wr(IX_PIN_MIN, 32'h3C);
    wr(IX_PIN_MAX, 32'h64);
    watch(1200);
    rd(IX_MEAS_PCT);
    chk("below min", 32'h0, rv);
    half <= 16'h0000;
    $display("test pulse input done");
  endtask : t_pulse_in
  // 100 kHz is 1250 cycles a period; 12500 cycles hold ten of them
  task automatic t_pulse_out();
    wr(IX_MODE, 32'h2);
    wr(IX_OTYPE, 32'h3);
    wr(IX_POUT_PCT, 32'h2710);
    watch(12500);
    chk("full scale", 32'h1, 32'(edg_n >= 9 && edg_n <= 11));
    wr(IX_POUT_PCT, 32'h1388);
    watch(12500);
    chk("half scale", 32'h1, 32'(edg_n >= 4 && edg_n <= 6));
    wr(IX_POUT_MIN, 32'h4E20);
    wr(IX_POUT_PCT, 32'h0);
    watch(12500);
    chk("zero scale", 32'h1, 32'(edg_n >= 1 && edg_n <= 3));
    $display("test pulse output done");
  endtask : t_pulse_out
  // Each output type at both levels, then modes that must release the pin
  task automatic t_driver();
    logic eo;
    logic po;
    wr(IX_MODE, 32'h1);
    for (int ot = 0; ot < 4; ot++) begin
      for (int lv = 0; lv < 2; lv++) begin
        wr(IX_OTYPE, 32'(ot));
        wr(IX_OUT_LVL, 32'(lv));
        repeat (2) @(posedge clk);
        #1;
        eo = (ot == 0) ? 1'b1 : ((ot == 3) ? 1'b0 : ~lv[0]);
        po = (ot == 3) ? lv[0] : (ot == 2);
        chk("output enable", {31'h0, eo}, {31'h0, pin_oe_n});
        if (ot != 0) chk("output level", {31'h0, po}, {31'h0, pin_out});
      end
    end
    wr(IX_MODE, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk("inactive released", 32'h1, {31'h0, pin_oe_n});
    wr(IX_MODE, 32'h3);
    repeat (2) @(posedge clk);
    #1;
    chk("input released", 32'h1, {31'h0, pin_oe_n});
    $display("test driver done");
  endtask : t_driver
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_defaults();
    t_events();
    t_filters();
    t_pulse_in();
    t_pulse_out();
    t_driver();
    conclude();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH run length expected end seen limit");
    conclude();
  end
endmodule : tb_configurable_terminal_io
